// ==== design/motor_pwm_pkg.sv ====
// constants for the motor pwm and mode timer block
// assumes a 16-bit register port with byte addresses as printed
package motor_pwm_pkg;

  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [15:0] ADDR_MODE_TIMER_CTRL_A = 16'h1FA4;
  localparam logic [15:0] ADDR_MODE_TIMER_CTRL_B = 16'h1FA5;
  localparam logic [15:0] ADDR_MODE_TIMER_CAP    = 16'h1FA6;
  localparam logic [15:0] ADDR_MODE_COMPARE_ONE  = 16'h1FA8;
  localparam logic [15:0] ADDR_MODE_COMPARE_TWO  = 16'h1FAA;
  localparam logic [15:0] ADDR_MODE_COMPARE_3    = 16'h1FAC;
  localparam logic [15:0] ADDR_PWM_CTRL_A        = 16'h1FAE;
  localparam logic [15:0] ADDR_PWM_CTRL_B        = 16'h1FAF;
  localparam logic [15:0] ADDR_PHASE_OUTPUT_CTRL = 16'h1FB2;
  localparam logic [15:0] ADDR_DEAD_TIME_SETTING = 16'h1FBE;

  // ----------------------------------------------------------------
  // mode_timer_ctrl_a fields
  // ----------------------------------------------------------------
  localparam int MT_ENABLE      = 0;
  localparam int MT_POS_RESET   = 1;
  localparam int MT_SW_RESET    = 2;
  localparam int MT_OVL_RESET   = 3;
  localparam int MT_T3_RESET    = 4;
  localparam int MT_CLK_LSB     = 5;
  // mode_timer_ctrl_b capture options
  localparam int CAP_POS        = 1;
  localparam int CAP_SW         = 2;
  localparam int CAP_OVL        = 3;

  // ----------------------------------------------------------------
  // pwm_ctrl_a fields
  // ----------------------------------------------------------------
  localparam int PWM_ENABLE     = 0;
  localparam int PWM_CENTER     = 1;
  localparam int PWM_IRQ_LSB    = 2;
  localparam int PWM_LOW_POL    = 4;
  localparam int PWM_UP_POL     = 5;
  localparam int PWM_DUTY_INDEP = 6;
  localparam int PWM_HALF_IRQ   = 7;

  // ----------------------------------------------------------------
  // phase_output_ctrl fields
  // ----------------------------------------------------------------
  localparam int OUT_SYNC_LSB   = 6;
  localparam int OUT_PWM_SEL    = 8;
  localparam int OUT_PWM_SYNC   = 11;
  localparam int OUT_PAT_LSB    = 12;
  localparam int OUT_DIR        = 15;

  // mode timer clock codes; the rest are reserved and stop the timer
  localparam logic [2:0] MTCLK_DIV8   = 3'h0;
  localparam logic [2:0] MTCLK_DIV16  = 3'h2;
  localparam logic [2:0] MTCLK_DIV32  = 3'h4;
  localparam logic [2:0] MTCLK_DIV64  = 3'h6;
  localparam logic [2:0] MTCLK_DIV128 = 3'h1;

  // output update sources
  localparam logic [1:0] SYNC_NONE    = 2'h0;
  localparam logic [1:0] SYNC_POS     = 2'h1;
  localparam logic [1:0] SYNC_TIMER1  = 2'h2;
  localparam logic [1:0] SYNC_TIMER2  = 2'h3;

  // dead time unit in clock cycles (8 / system clock)
  localparam int DEAD_UNIT_CYCLES = 8;
  localparam int DEAD_UNIT_SHIFT  = $clog2(DEAD_UNIT_CYCLES);
  localparam logic [15:0] RESET_VALUE = 16'h0000;

endpackage

// ==== design/motor_pwm_mode_timer_ctrl.sv ====
// mode timer and three-phase pwm waveform stage for a motor drive unit
// assumes overload and position events are one-cycle pulses on clock,
// and pwm period and duty values come from same-clock registers outside
//
// Operation
// [RULE_01] overload event clears timer when option enabled
// [RULE_02] writing one to bit 2 clears timer
// [RULE_03] position event clears timer when bit 1 set
// [RULE_04] enable bit starts and stops the timer
// [RULE_05] read-only capture plus three compare registers
// [RULE_06] pwm clock is clock over 2,4,8,16
// [RULE_07] pwm interrupt every 1,2,4,8 periods
// [RULE_08] half-period interrupt when bit 7 and field 00
// [RULE_09] duty mode: common U duty or independent
// [RULE_10] bits 5 and 4 set output active levels
// [RULE_11] mode bit picks sawtooth or triangle carrier
// [RULE_12] bit 0 enables waveform output
// [RULE_13] dead time is count times eight clocks
// [RULE_14] bit F reads count direction
// [RULE_15] bits E to C hold expected position pattern
// [RULE_16] sync bit ties output update to pwm period
// [RULE_17] per-phase select of pwm or fixed level
// [RULE_18] two-bit field picks output update event
// [RULE_19] timer clock over 8 to 128, others reserved
// [RULE_20] timer 3 event clears timer when enabled
// [RULE_21] synced output settings wait in a shadow
module motor_pwm_mode_timer_ctrl #(
  parameter int PWM_WIDTH = 12
) (
  // clock and reset
  input  wire logic                 clock,
  input  wire logic                 rst,
  // register port
  input  wire logic [15:0]          regAddr,
  input  wire logic [15:0]          regWrData,
  input  wire logic                 regWrite,
  input  wire logic                 regRead,
  output logic      [15:0]          regRdData,
  // events from neighbouring logic
  input  wire logic                 overloadEvent,
  input  wire logic                 positionEvent,
  // period and duty values
  input  wire logic [PWM_WIDTH-1:0] pwmPeriod,
  input  wire logic [PWM_WIDTH-1:0] dutyU,
  input  wire logic [PWM_WIDTH-1:0] dutyV,
  input  wire logic [PWM_WIDTH-1:0] dutyW,
  // results
  output logic      [2:0]           upperOut,
  output logic      [2:0]           lowerOut,
  output logic                      pwmIrq,
  output logic      [2:0]           timerEvent,
  output logic      [2:0]           expectedPattern
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  localparam int DEAD_W_PAD = motor_pwm_pkg::DEAD_UNIT_SHIFT;

  typedef struct packed {
    logic [7:0]                  ctrlA;
    logic [3:0]                  ctrlB;
    logic [15:0]                 capture;
    logic [2:0][15:0]            cmp;
    logic [7:0]                  pwmA;
    logic [1:0]                  pwmB;
    logic [5:0]                  dead;
    logic [14:0]                 outShadow;
    logic [14:0]                 outActive;
    logic [15:0]                 modeTimer;
    logic [6:0]                  pre;
    logic [PWM_WIDTH-1:0]        pwmCnt;
    logic                        dirDown;
    logic [2:0]                  periodDiv;
    logic                        irq;
    logic [2:0]                  tmrEvt;
    logic [2:0][5+DEAD_W_PAD:0]  dtCnt;
    logic [2:0]                  rawPrev;
    logic [2:0]                  upper;
    logic [2:0]                  lower;
    logic [15:0]                 rdata;
  } state_t;

  state_t state_reg;
  state_t state_next;

  logic                 mtTick;
  logic                 pwmTick;
  logic                 mtClear;
  logic                 periodStart;
  logic                 halfPoint;
  logic                 loadOut;
  logic [2:0]           irqMask;
  logic [2:0]           divNext;
  logic [PWM_WIDTH-1:0] duty [3];
  logic                 raw;
  logic                 upAct;
  logic                 loAct;
  logic                 upLvl;
  logic                 loLvl;
  logic                 wrA;

  always_comb begin
    duty[0] = dutyU;
    duty[1] = state_reg.pwmA[motor_pwm_pkg::PWM_DUTY_INDEP] ? dutyV : dutyU; // RULE_09
    duty[2] = state_reg.pwmA[motor_pwm_pkg::PWM_DUTY_INDEP] ? dutyW : dutyU; // RULE_09
  end

  always_comb begin
    state_next  = state_reg;
    state_next.irq    = 1'b0;
    state_next.tmrEvt = 3'h0;
    state_next.pre    = state_reg.pre + 7'h01;
    periodStart = 1'b0;
    halfPoint   = 1'b0;
    raw         = 1'b0;
    upAct       = 1'b0;
    loAct       = 1'b0;
    upLvl       = 1'b0;
    loLvl       = 1'b0;
    wrA         = regWrite && (regAddr == motor_pwm_pkg::ADDR_MODE_TIMER_CTRL_A);

    // ----------------------------------------------------------------
    // prescaler taps
    // ----------------------------------------------------------------
    unique case (state_reg.ctrlA[7:5]) // RULE_19
      motor_pwm_pkg::MTCLK_DIV8:   mtTick = (state_reg.pre[2:0] == 3'h7);
      motor_pwm_pkg::MTCLK_DIV16:  mtTick = (state_reg.pre[3:0] == 4'hF);
      motor_pwm_pkg::MTCLK_DIV32:  mtTick = (state_reg.pre[4:0] == 5'h1F);
      motor_pwm_pkg::MTCLK_DIV64:  mtTick = (state_reg.pre[5:0] == 6'h3F);
      motor_pwm_pkg::MTCLK_DIV128: mtTick = (state_reg.pre == 7'h7F);
      default:                     mtTick = 1'b0;
    endcase
    unique case (state_reg.pwmB) // RULE_06
      2'h0: pwmTick = state_reg.pre[0];
      2'h1: pwmTick = (state_reg.pre[1:0] == 2'h3);
      2'h2: pwmTick = (state_reg.pre[2:0] == 3'h7);
      2'h3: pwmTick = (state_reg.pre[3:0] == 4'hF);
    endcase

    // ----------------------------------------------------------------
    // mode timer
    // ----------------------------------------------------------------
    mtClear = (wrA && regWrData[motor_pwm_pkg::MT_SW_RESET])                      // RULE_02
            || (positionEvent && state_reg.ctrlA[motor_pwm_pkg::MT_POS_RESET])     // RULE_03
            || (overloadEvent && state_reg.ctrlA[motor_pwm_pkg::MT_OVL_RESET])     // RULE_01
            || (state_reg.tmrEvt[2] && state_reg.ctrlA[motor_pwm_pkg::MT_T3_RESET]); // RULE_20
    if (mtClear) begin
      state_next.modeTimer = 16'h0000;
    end else if (state_reg.ctrlA[motor_pwm_pkg::MT_ENABLE] && mtTick) begin // RULE_04
      for (int i = 0; i < 3; i++) begin
        state_next.tmrEvt[i] = (state_reg.modeTimer == state_reg.cmp[i]);
      end
      state_next.modeTimer = state_reg.modeTimer + 16'h0001;
    end
    // capture takes the value before any clear in the same cycle
    if ((regWrite && regAddr == motor_pwm_pkg::ADDR_MODE_TIMER_CTRL_B
         && regWrData[motor_pwm_pkg::CAP_SW])
        || (positionEvent && state_reg.ctrlB[motor_pwm_pkg::CAP_POS])
        || (overloadEvent && state_reg.ctrlB[motor_pwm_pkg::CAP_OVL])) begin
      state_next.capture = state_reg.modeTimer; // RULE_05
    end

    // ----------------------------------------------------------------
    // pwm carrier
    // ----------------------------------------------------------------
    if (!state_reg.pwmA[motor_pwm_pkg::PWM_ENABLE]) begin // RULE_12
      state_next.pwmCnt    = '0;
      state_next.dirDown   = 1'b0;
      state_next.periodDiv = 3'h0;
    end else if (pwmTick) begin
      if (!state_reg.pwmA[motor_pwm_pkg::PWM_CENTER]) begin // RULE_11
        state_next.dirDown = 1'b0;
        halfPoint = (state_reg.pwmCnt == (pwmPeriod >> 1) - 1'b1);
        if (state_reg.pwmCnt >= pwmPeriod - 1'b1) begin
          state_next.pwmCnt = '0;
          periodStart = 1'b1;
        end else begin
          state_next.pwmCnt = state_reg.pwmCnt + 1'b1;
        end
      end else if (!state_reg.dirDown) begin
        if (state_reg.pwmCnt >= pwmPeriod) begin
          state_next.dirDown = 1'b1;
          state_next.pwmCnt  = state_reg.pwmCnt - 1'b1;
          halfPoint = 1'b1;
        end else begin
          state_next.pwmCnt = state_reg.pwmCnt + 1'b1;
        end
      end else if (state_reg.pwmCnt == '0) begin
        state_next.dirDown = 1'b0;
        state_next.pwmCnt  = state_reg.pwmCnt + 1'b1;
        periodStart = 1'b1;
      end else begin
        state_next.pwmCnt = state_reg.pwmCnt - 1'b1;
      end
    end

    // ----------------------------------------------------------------
    // pwm interrupt divider
    // ----------------------------------------------------------------
    unique case (state_reg.pwmA[3:2]) // RULE_07
      2'h0: irqMask = 3'h0;
      2'h1: irqMask = 3'h1;
      2'h2: irqMask = 3'h3;
      2'h3: irqMask = 3'h7;
    endcase
    divNext = state_reg.periodDiv + 3'h1;
    if (periodStart) begin
      state_next.periodDiv = divNext;
    end
    if (state_reg.pwmA[motor_pwm_pkg::PWM_HALF_IRQ] && state_reg.pwmA[3:2] == 2'h0) begin
      state_next.irq = periodStart || halfPoint; // RULE_08
    end else begin
      state_next.irq = periodStart && ((divNext & irqMask) == 3'h0); // RULE_07
    end

    // ----------------------------------------------------------------
    // output settings: shadow and active copy
    // ----------------------------------------------------------------
    unique case (state_reg.outShadow[7:6]) // RULE_18
      motor_pwm_pkg::SYNC_NONE:
        loadOut = !state_reg.outShadow[motor_pwm_pkg::OUT_PWM_SYNC] || periodStart; // RULE_16
      motor_pwm_pkg::SYNC_POS:    loadOut = positionEvent;
      motor_pwm_pkg::SYNC_TIMER1: loadOut = state_reg.tmrEvt[0];
      motor_pwm_pkg::SYNC_TIMER2: loadOut = state_reg.tmrEvt[1];
    endcase
    if (loadOut) begin
      state_next.outActive = state_reg.outShadow; // RULE_21
    end

    // ----------------------------------------------------------------
    // per-phase waveform, dead time, override and polarity
    // ----------------------------------------------------------------
    for (int i = 0; i < 3; i++) begin
      raw = state_reg.pwmA[motor_pwm_pkg::PWM_ENABLE] && (state_reg.pwmCnt < duty[i]);
      if (raw != state_reg.rawPrev[i]) begin
        // both switches stay off while the dead time runs
        state_next.dtCnt[i]   = {state_reg.dead, DEAD_W_PAD'(0)}; // RULE_13
        state_next.rawPrev[i] = raw;
      end else if (state_reg.dtCnt[i] != '0) begin
        state_next.dtCnt[i] = state_reg.dtCnt[i] - 1'b1;
      end
      upAct = state_reg.rawPrev[i] && (state_reg.dtCnt[i] == '0);
      loAct = !state_reg.rawPrev[i] && (state_reg.dtCnt[i] == '0);
      if (state_reg.outActive[motor_pwm_pkg::OUT_PWM_SEL + i]) begin // RULE_17
        upLvl = upAct;
        loLvl = loAct;
      end else begin
        upLvl = state_reg.outActive[2*i+1];
        loLvl = state_reg.outActive[2*i];
      end
      if (!state_reg.pwmA[motor_pwm_pkg::PWM_ENABLE]) begin // RULE_12
        upLvl = 1'b0;
        loLvl = 1'b0;
      end
      // RULE_10
      state_next.upper[i] = upLvl ~^ state_reg.pwmA[motor_pwm_pkg::PWM_UP_POL];
      state_next.lower[i] = loLvl ~^ state_reg.pwmA[motor_pwm_pkg::PWM_LOW_POL];
    end

    // ----------------------------------------------------------------
    // register writes
    // ----------------------------------------------------------------
    if (regWrite) begin
      unique case (regAddr)
        motor_pwm_pkg::ADDR_MODE_TIMER_CTRL_A:
          state_next.ctrlA = regWrData[7:0] & 8'hFB; // RULE_02
        motor_pwm_pkg::ADDR_MODE_TIMER_CTRL_B:
          state_next.ctrlB = regWrData[3:0] & 4'hA;
        motor_pwm_pkg::ADDR_MODE_COMPARE_ONE:  state_next.cmp[0] = regWrData; // RULE_05
        motor_pwm_pkg::ADDR_MODE_COMPARE_TWO:  state_next.cmp[1] = regWrData;
        motor_pwm_pkg::ADDR_MODE_COMPARE_3:    state_next.cmp[2] = regWrData;
        motor_pwm_pkg::ADDR_PWM_CTRL_A:        state_next.pwmA   = regWrData[7:0];
        motor_pwm_pkg::ADDR_PWM_CTRL_B:        state_next.pwmB   = regWrData[1:0];
        motor_pwm_pkg::ADDR_PHASE_OUTPUT_CTRL: state_next.outShadow = regWrData[14:0]; // RULE_15
        motor_pwm_pkg::ADDR_DEAD_TIME_SETTING: state_next.dead   = regWrData[5:0];
        default: ;
      endcase
    end

    // ----------------------------------------------------------------
    // register reads, answered one cycle later
    // ----------------------------------------------------------------
    state_next.rdata = 16'h0000;
    if (regRead) begin
      unique case (regAddr)
        motor_pwm_pkg::ADDR_MODE_TIMER_CTRL_A: state_next.rdata = {8'h00, state_reg.ctrlA};
        motor_pwm_pkg::ADDR_MODE_TIMER_CTRL_B: state_next.rdata = {12'h000, state_reg.ctrlB};
        motor_pwm_pkg::ADDR_MODE_TIMER_CAP:    state_next.rdata = state_reg.capture;
        motor_pwm_pkg::ADDR_MODE_COMPARE_ONE:  state_next.rdata = state_reg.cmp[0];
        motor_pwm_pkg::ADDR_MODE_COMPARE_TWO:  state_next.rdata = state_reg.cmp[1];
        motor_pwm_pkg::ADDR_MODE_COMPARE_3:    state_next.rdata = state_reg.cmp[2];
        motor_pwm_pkg::ADDR_PWM_CTRL_A:        state_next.rdata = {8'h00, state_reg.pwmA};
        motor_pwm_pkg::ADDR_PWM_CTRL_B:        state_next.rdata = {14'h0000, state_reg.pwmB};
        motor_pwm_pkg::ADDR_PHASE_OUTPUT_CTRL:
          state_next.rdata = {state_reg.dirDown, state_reg.outShadow}; // RULE_14
        motor_pwm_pkg::ADDR_DEAD_TIME_SETTING: state_next.rdata = {10'h000, state_reg.dead};
        default: state_next.rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign regRdData       = state_reg.rdata;
  assign upperOut        = state_reg.upper;
  assign lowerOut        = state_reg.lower;
  assign pwmIrq          = state_reg.irq;
  assign timerEvent      = state_reg.tmrEvt;
  assign expectedPattern = state_reg.outActive[14:12];

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_sw_reset_clears: assert property ( // RULE_02
    wrA && regWrData[2] |=> state_reg.modeTimer == 16'h0000)
    else $error("software reset did not clear mode timer");

  a_pos_reset_clears: assert property ( // RULE_03
    positionEvent && state_reg.ctrlA[1] |=> state_reg.modeTimer == 16'h0000)
    else $error("position event did not clear mode timer");

  a_ovl_reset_clears: assert property ( // RULE_01
    overloadEvent && state_reg.ctrlA[3] |=> state_reg.modeTimer == 16'h0000)
    else $error("overload event did not clear mode timer");

  a_t3_reset_clears: assert property ( // RULE_20
    state_reg.tmrEvt[2] && state_reg.ctrlA[4] |=> state_reg.modeTimer == 16'h0000)
    else $error("timer 3 event did not clear mode timer");

  a_timer_disabled_holds: assert property ( // RULE_04
    !state_reg.ctrlA[0] && !mtClear |=> $stable(state_reg.modeTimer))
    else $error("mode timer moved while disabled");

  a_pwm_div_two: assert property ( // RULE_06
    pwmTick && state_reg.pwmB == 2'h0 && !regWrite ##1 !regWrite |-> !pwmTick ##1 pwmTick)
    else $error("pwm clock over two misspaced");

  a_dir_readback: assert property ( // RULE_14
    regRead && regAddr == motor_pwm_pkg::ADDR_PHASE_OUTPUT_CTRL
    |=> regRdData[15] == $past(state_reg.dirDown))
    else $error("direction bit read wrong");

  a_disabled_idle: assert property ( // RULE_12
    (!state_reg.pwmA[0] && $stable(state_reg.pwmA))[*2]
    |-> upperOut == {3{~state_reg.pwmA[5]}} && lowerOut == {3{~state_reg.pwmA[4]}})
    else $error("outputs active while synthesis disabled");

  a_no_shoot_through: assert property ( // RULE_13
    state_reg.outActive[8] && state_reg.pwmA[0] && $stable(state_reg.pwmA)
    && $stable(state_reg.outActive)
    |=> !((upperOut[0] == state_reg.pwmA[5]) && (lowerOut[0] == state_reg.pwmA[4])))
    else $error("U upper and lower active together");

  a_timer_counts: assert property ( // RULE_04
    state_reg.ctrlA[0] && mtTick && !mtClear
    |=> state_reg.modeTimer == $past(state_reg.modeTimer) + 16'h0001)
    else $error("enabled mode timer missed a tick");

  a_sync_holds_active: assert property ( // RULE_21
    state_reg.outShadow[7:6] == motor_pwm_pkg::SYNC_POS && !positionEvent
    |=> $stable(state_reg.outActive))
    else $error("active output changed without sync event");

endmodule // motor_pwm_mode_timer_ctrl

// ==== verif/inverter_stage_model.sv ====
// behavioural inverter power stage behind the three phase legs
// assumes the bench tells it the active levels it has programmed
module inverter_stage_model (
  // clock and control
  input  wire logic       clock,
  input  wire logic       clear,
  input  wire logic       upActHigh,
  input  wire logic       lowActHigh,
  // gate drive
  input  wire logic [2:0] upperOut,
  input  wire logic [2:0] lowerOut,
  // leg state
  output logic      [2:0] phaseLevel,
  output logic            shootSeen
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] upOn;
  logic [2:0] lowOn;
  assign upOn  = upperOut ~^ {3{upActHigh}};
  assign lowOn = lowerOut ~^ {3{lowActHigh}};
  initial phaseLevel = 3'h0;
  initial shootSeen = 1'b0;
  always @(posedge clock) begin
    // a floating leg shows no stable level, so the last one is inverted
    for (int i = 0; i < 3; i++) begin
      phaseLevel[i] <= upOn[i] ? 1'b1 : lowOn[i] ? 1'b0 : ~phaseLevel[i];
    end
    // both switches of one leg on shorts the supply
    shootSeen <= clear ? 1'b0 : shootSeen | (|(upOn & lowOn));
  end
endmodule // inverter_stage_model

// ==== verif/tb_motor_pwm_mode_timer_ctrl.sv ====
// self-checking bench for the motor pwm and mode timer block
// assumes the inverter model on the outputs and a 50 MHz clock
module tb_motor_pwm_mode_timer_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic [15:0] regAddr = 16'h0000;
  logic [15:0] regWrData = 16'h0000;
  logic        regWrite = 1'b0;
  logic        regRead = 1'b0;
  logic [15:0] regRdData;
  logic        overloadEvent = 1'b0;
  logic        positionEvent = 1'b0;
  logic [11:0] pwmPeriod = 12'h010;
  logic [11:0] dutyU = 12'h008;
  logic [11:0] dutyV = 12'h000;
  logic [11:0] dutyW = 12'h004;
  logic [2:0]  upperOut;
  logic [2:0]  lowerOut;
  logic        pwmIrq;
  logic [2:0]  timerEvent;
  logic [2:0]  expectedPattern;
  logic        upHigh = 1'b0;
  logic        lowHigh = 1'b0;
  logic        clr = 1'b0;
  logic [2:0]  phaseLevel;
  logic        shootSeen;
  logic [15:0] d;
  int          errCount = 0;
  int          checkCount = 0;
  int          n;
  int          t;

  motor_pwm_mode_timer_ctrl uut (.clock(clock), .rst(rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .overloadEvent(overloadEvent), .positionEvent(positionEvent), .pwmPeriod(pwmPeriod),
    .dutyU(dutyU), .dutyV(dutyV), .dutyW(dutyW), .upperOut(upperOut), .lowerOut(lowerOut),
    .pwmIrq(pwmIrq), .timerEvent(timerEvent), .expectedPattern(expectedPattern));
  inverter_stage_model inv (.clock(clock), .clear(clr), .upActHigh(upHigh),
    .lowActHigh(lowHigh), .upperOut(upperOut), .lowerOut(lowerOut),
    .phaseLevel(phaseLevel), .shootSeen(shootSeen));

  always #10 clock = ~clock;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checkCount++;
    if (got !== exp) begin
      errCount++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic chkn(input int got, input int exp);
    checkCount++;
    if (got != exp) begin
      errCount++;
      $display("unexpected at %0t: count %0d want %0d", $time, got, exp);
    end
  endtask
  task automatic step();
    @(posedge clock);
    #1;
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] v);
    @(posedge clock);
    regAddr <= a;
    regWrData <= v;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, output logic [15:0] v);
    @(posedge clock);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    #1 v = regRdData;
  endtask
  task automatic pulse(input logic ovl);
    @(posedge clock);
    overloadEvent <= ovl;
    positionEvent <= ~ovl;
    @(posedge clock);
    overloadEvent <= 1'b0;
    positionEvent <= 1'b0;
  endtask
  task automatic capt(output logic [15:0] v);
    wr(motor_pwm_pkg::ADDR_MODE_TIMER_CTRL_B, 16'h0004);
    rd(motor_pwm_pkg::ADDR_MODE_TIMER_CAP, v);
  endtask
  // the first gaps after a change are partial, so the third is kept
  task automatic gap(output int g);
    for (int k = 0; k < 3; k++) begin
      g = 1;
      step();
      while (pwmIrq !== 1'b1 && g < 5000) begin
        step();
        g++;
      end
    end
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    wr(motor_pwm_pkg::ADDR_MODE_COMPARE_TWO, 16'hA5C3);
    wr(motor_pwm_pkg::ADDR_MODE_TIMER_CAP, 16'hFFFF);
    wr(16'h1FA0, 16'hFFFF);
    rd(motor_pwm_pkg::ADDR_MODE_COMPARE_TWO, d);
    chk(d, 16'hA5C3);
    rd(motor_pwm_pkg::ADDR_MODE_TIMER_CAP, d);
    chk(d, 16'h0000);
    rd(16'h1FA0, d);
    chk(d, 16'h0000);
  endtask
  task automatic t_timer();
    wr(motor_pwm_pkg::ADDR_MODE_COMPARE_ONE, 16'h0003);
    wr(motor_pwm_pkg::ADDR_MODE_TIMER_CTRL_A, 16'h0005);
    t = 0;
    while (timerEvent[0] !== 1'b1 && t < 60) begin
      step();
      t++;
    end
    chkn(int'(t < 60), 1);
    wr(motor_pwm_pkg::ADDR_MODE_TIMER_CTRL_A, 16'h0004);
    repeat (40) step();
    capt(d);
    chk(d, 16'h0000);
    // bit 0 of e arms the option, bit 1 picks overload over position
    for (int e = 0; e < 4; e++) begin
      wr(motor_pwm_pkg::ADDR_MODE_TIMER_CTRL_A,
         e[0] ? 16'h0005 | (16'h0001 << (e[1] ? 3 : 1)) : 16'h0005);
      repeat (100) step();
      pulse(e[1]);
      capt(d);
      chk(16'(d < 16'h0002), 16'(e[0]));
    end
    wr(motor_pwm_pkg::ADDR_MODE_COMPARE_3, 16'h0002);
    wr(motor_pwm_pkg::ADDR_MODE_TIMER_CTRL_A, 16'h0015);
    repeat (100) step();
    capt(d);
    chk(16'(d < 16'h0004), 16'h0001);
    wr(motor_pwm_pkg::ADDR_MODE_TIMER_CTRL_A, 16'h0065);
    repeat (140) step();
    capt(d);
    chk(d, 16'h0000);
  endtask
  task automatic t_pwm();
    for (int c = 0; c < 4; c++) begin
      wr(motor_pwm_pkg::ADDR_PWM_CTRL_B, 16'(c));
      wr(motor_pwm_pkg::ADDR_PWM_CTRL_A, 16'h0001 | 16'(c << 2));
      gap(n);
      chkn(n, 32 << (2 * c));
    end
    wr(motor_pwm_pkg::ADDR_PWM_CTRL_B, 16'h0000);
    wr(motor_pwm_pkg::ADDR_PWM_CTRL_A, 16'h0003);
    gap(n);
    chkn(n, 64);
    t = 0;
    for (int k = 0; k < 40; k++) begin
      rd(motor_pwm_pkg::ADDR_PHASE_OUTPUT_CTRL, d);
      t = t | (d[15] === 1'b1 ? 2 : d[15] === 1'b0 ? 1 : 0);
    end
    chkn(t, 3);
    wr(motor_pwm_pkg::ADDR_PWM_CTRL_A, 16'h0083);
    gap(n);
    chkn(n, 32);
    wr(motor_pwm_pkg::ADDR_PWM_CTRL_A, 16'h0081);
    gap(n);
    chkn(n, 16);
    wr(motor_pwm_pkg::ADDR_PWM_CTRL_A, 16'h0087);
    gap(n);
    chkn(n, 128);
  endtask
  task automatic t_levels();
    wr(motor_pwm_pkg::ADDR_PWM_CTRL_A, 16'h0000);
    wr(motor_pwm_pkg::ADDR_PHASE_OUTPUT_CTRL, 16'h5006);
    repeat (4) step();
    chk(16'({upperOut, lowerOut}), 16'h003F);
    wr(motor_pwm_pkg::ADDR_PWM_CTRL_A, 16'h0001);
    repeat (4) step();
    chk(16'({upperOut, lowerOut}), 16'h0035);
    chk(16'(expectedPattern), 16'h0005);
    wr(motor_pwm_pkg::ADDR_PWM_CTRL_A, 16'h0031);
    upHigh <= 1'b1;
    lowHigh <= 1'b1;
    repeat (4) step();
    chk(16'({upperOut, lowerOut}), 16'h000A);
    wr(motor_pwm_pkg::ADDR_PHASE_OUTPUT_CTRL, 16'h5049);
    repeat (4) step();
    chk(16'({upperOut, lowerOut}), 16'h000A);
    pulse(1'b0);
    repeat (3) step();
    chk(16'({upperOut, lowerOut}), 16'h0011);
    chk(16'(phaseLevel[1:0]), 16'h0002);
    rd(motor_pwm_pkg::ADDR_PHASE_OUTPUT_CTRL, d);
    chk(d, 16'h5049);
  endtask
  task automatic t_dead();
    wr(motor_pwm_pkg::ADDR_PWM_CTRL_A, 16'h0001);
    upHigh <= 1'b0;
    lowHigh <= 1'b0;
    wr(motor_pwm_pkg::ADDR_DEAD_TIME_SETTING, 16'h0001);
    wr(motor_pwm_pkg::ADDR_PHASE_OUTPUT_CTRL, 16'h0700);
    clr <= 1'b1;
    @(posedge clock);
    clr <= 1'b0;
    step();
    t = 0;
    while (upperOut[0] !== 1'b0 && t < 200) begin
      step();
      t++;
    end
    chk(16'(upperOut[1]), 16'h0000);
    while (upperOut[0] !== 1'b1 && t < 400) begin
      step();
      t++;
    end
    n = 0;
    while (upperOut[0] === 1'b1 && lowerOut[0] === 1'b1 && n < 100) begin
      step();
      n++;
    end
    chkn(n, 8);
    wr(motor_pwm_pkg::ADDR_PWM_CTRL_A, 16'h0041);
    repeat (40) step();
    chk(16'(upperOut[1]), 16'h0001);
    chk(16'(shootSeen), 16'h0000);
  endtask

  // ----------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------
  task automatic endSim();
    $display("errors %0d checks %0d", errCount, checkCount);
    if (errCount == 0 && checkCount > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #1000000;
    errCount++;
    $display("unexpected at %0t: run did not finish", $time);
    endSim();
  end
  initial begin
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    t_regs();
    t_timer();
    t_pwm();
    t_levels();
    t_dead();
    endSim();
  end
endmodule // tb_motor_pwm_mode_timer_ctrl
